// >>> logic/uart_pkg.sv
// Shared constants and types for the asynchronous serial transmitter block
package uart_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_BAUD = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  // Baud modulo divider
  localparam int DIV_W = 13;
  localparam logic [12:0] DIV_RST = 13'h001A;
  // Control register fields
  localparam int CTRL_W = 11;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam int CB_TX_ON = 0;
  localparam int CB_RX_ON = 1;
  localparam int CB_NINE = 2;
  localparam int CB_PAR_EN = 3;
  localparam int CB_PAR_ODD = 4;
  localparam int CB_INV = 5;
  localparam int CB_BRK = 6;
  localparam int CB_LOOP = 7;
  localparam int CB_SWIRE = 8;
  localparam int CB_WAKE_ADDR = 9;
  localparam int CB_RWU = 10;
  // Status register fields
  localparam int SB_VACANT = 0;
  localparam int SB_TC = 1;
  localparam int SB_RXFULL = 2;
  localparam int SB_IDLE = 3;
  localparam int SB_OVR = 4;
  localparam int SB_NOISE = 5;
  localparam int SB_FRAME = 6;
  localparam int SB_PAR = 7;
  // Oversampling phases within one bit time
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_S0 = 4'h7;
  localparam logic [3:0] PH_S2 = 4'h9;
  // Frame lengths in bit times
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  localparam logic [3:0] BREAK_LEN = 4'hD;
  localparam logic [12:0] SR_IDLE = 13'h1FFF;
  localparam logic [12:0] SR_BREAK = 13'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE = 2'b01,
    TX_DATA = 2'b10,
    TX_BRK = 2'b11
  } tx_state_t;
endpackage

// >>> logic/uart_top.sv
// Serial transmitter and receiver with an AXI4-Lite register slave
//
// Notes on behaviour
// R1: Baud generator is clocked only by the bus clock.
// R2: Baud rate set by a 13-bit modulo divider of that clock.
// R3: Receiver realigns its sample phase on every falling line edge.
// R4: Remote end must match baud within about 4.5 or 4 percent.
// R5: With invert clear, as after reset, idle line is high.
// R6: With invert set, output is the complement of the normal waveform.
// R7: Enabling the transmitter first sends one idle frame as preamble.
// R8: After the preamble the line idles until a character is buffered.
// R9: Writing the data register fills the transmit buffer.
// R10: Shift register holds 10 bits for 8-bit data, 11 for 9-bit.
// R11: An 8-bit frame is start bit, eight data bits, stop bit.
// R12: Free shifter takes the buffer on a baud tick; vacant flag sets.
// R13: Character length selects 8 or 9 data bits.
// R14: Parity is generated on transmit and checked on receive.
// R15: An optional 13-bit break character can be sent.
// R16: Receiver wakes on idle line or on an address-mark character.
// R17: Transmitter and receiver are double-buffered with separate enables.
// R18: Buffer vacant and transmit complete flags are polled by software.
// R19: Receiver flags full, overrun, parity, framing, noise and idle.
// R20: All serial activity halts during stop mode.
// R21: Full-duplex link in non-return-to-zero format.
// R22: Start bit active, stop bit idle, data least significant first.
// R23: Loop mode and single-wire mode besides normal operation.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module uart_top
  import uart_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic stop_i,
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_o,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);

  // Index 0..3 for a mapped word, bit 2 high when the address hits
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      OFF_BAUD: reg_sel = 3'h4;
      OFF_CTRL: reg_sel = 3'h5;
      OFF_STAT: reg_sel = 3'h6;
      OFF_DATA: reg_sel = 3'h7;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_merge = (old & ~m) | (nw & m);
  endfunction

  // Start bit low, data LSB first, parity in the top data slot, stop high
  function automatic logic [12:0] build_frame(input logic [8:0] data, input logic nine,
                                              input logic pe, input logic odd);
    logic [8:0] d;
    logic par;
    d = nine ? data : {1'b0, data[7:0]};
    par = (nine ? ^data[7:0] : ^data[6:0]) ^ odd;
    if (pe && nine) begin
      d[8] = par;
    end else if (pe) begin
      d[7] = par;
    end
    build_frame = nine ? {2'b11, 1'b1, d, 1'b0} : {3'b111, 1'b1, d[7:0], 1'b0};
  endfunction

  logic [DIV_W-1:0] div_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [8:0] tx_buf_q;
  logic vacant_q;
  logic [8:0] rx_buf_q;
  logic rx_full_q, idle_q, ovr_q, noise_q, frame_q, par_q;
  logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [DIV_W-1:0] baud_cnt_q;
  logic tick_q;
  tx_state_t tx_state_q;
  logic [12:0] tx_sr_q;
  logic [3:0] tx_cnt_q, tx_ph_q;
  logic tx_on_prev_q, pre_pend_q, txd_q, txd_oe_q;
  logic rx_busy_q, rx_prev_q;
  logic [3:0] rx_ph_q, rx_idx_q;
  logic [2:0] rx_samp_q;
  logic [8:0] rx_sr_q;
  logic rx_noise_q, rx_done_q, rx_fe_q, rx_pe_q, rx_nf_q, idle_evt_q, idle_arm_q;
  logic [8:0] rx_data_q;
  logic [7:0] idle_cnt_q;

  logic nine, tx_on, rx_on, tx_line, rx_line, rx_fall, tx_load, tx_free;
  logic wr_go, rd_go, data_wr, data_rd, rx_bit, rx_accept, tx_done;
  logic [2:0] wr_sel, rd_sel;
  logic [31:0] wr_word, rd_val, stat_word;
  logic [3:0] frame_len, n_data;

  assign nine = ctrl_q[CB_NINE];
  assign tx_on = ctrl_q[CB_TX_ON];
  assign rx_on = ctrl_q[CB_RX_ON];
  // R10: frame length by character size
  assign frame_len = nine ? FRAME9 : FRAME8;
  assign n_data = frame_len - 4'h2;
  assign tx_line = (tx_state_q == TX_IDLE) ? 1'b1 : tx_sr_q[0];
  // R23: loop feeds the receiver from the transmitter, single-wire from the pin
  assign rx_line = ctrl_q[CB_LOOP] ? tx_line : (ctrl_q[CB_SWIRE] ? txd_i : rxd_i);
  assign rx_fall = rx_prev_q && !rx_line && !stop_i;
  assign tx_free = tick_q && !stop_i && tx_on && (tx_state_q == TX_IDLE);
  // R8: leave idle only for a preamble, a break or a buffered character
  assign tx_load = tx_free && !pre_pend_q && !ctrl_q[CB_BRK] && !vacant_q;
  assign tx_done = tick_q && !stop_i && (tx_state_q != TX_IDLE) && (tx_ph_q == PH_LAST)
                   && (tx_cnt_q == 4'h1);
  assign rx_bit = (rx_samp_q[1] & rx_samp_q[0]) | (rx_samp_q[1] & rx_line)
                  | (rx_samp_q[0] & rx_line);

  // AXI4-Lite write channel: address and data accepted in either order
  assign wr_go = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  assign wr_sel = reg_sel(aw_addr_q);
  assign data_wr = wr_go && (wr_sel == 3'h7) && w_strb_q[0];
  assign rd_go = arvalid_i && ar_rdy_q;
  assign rd_sel = reg_sel(araddr_i);
  assign data_rd = rd_go && (rd_sel == 3'h7);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid_i && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        aw_addr_q <= awaddr_i;
      end
      if (wvalid_i && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        w_data_q <= wdata_i;
        w_strb_q <= wstrb_i;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_sel[2] ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready_i) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
    end
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    // R18: vacant and complete flags
    stat_word[SB_VACANT] = vacant_q;
    stat_word[SB_TC] = vacant_q && (tx_state_q == TX_IDLE) && !pre_pend_q;
    stat_word[SB_RXFULL] = rx_full_q;
    stat_word[SB_IDLE] = idle_q;
    stat_word[SB_OVR] = ovr_q;
    stat_word[SB_NOISE] = noise_q;
    stat_word[SB_FRAME] = frame_q;
    stat_word[SB_PAR] = par_q;
    case (rd_sel)
      3'h4: rd_val = {19'h00000, div_q};
      3'h5: rd_val = {21'h000000, ctrl_q};
      3'h6: rd_val = stat_word;
      3'h7: rd_val = {23'h000000, rx_buf_q};
      default: rd_val = 32'h0000_0000;
    endcase
    wr_word = 32'h0000_0000;
    case (wr_sel)
      3'h4: wr_word = lane_merge({19'h00000, div_q}, w_data_q, w_strb_q);
      3'h5: wr_word = lane_merge({21'h000000, ctrl_q}, w_data_q, w_strb_q);
      3'h6: wr_word = lane_merge(32'h0000_0000, w_data_q, w_strb_q);
      3'h7: wr_word = lane_merge({23'h000000, tx_buf_q}, w_data_q, w_strb_q);
      default: wr_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_sel[2] ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready_i) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end

  // Configuration; hardware clears the wakeup bit, which wins over a write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= DIV_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_go && wr_sel == 3'h4) begin
        div_q <= wr_word[DIV_W-1:0];
      end
      if (wr_go && wr_sel == 3'h5) begin
        ctrl_q <= wr_word[CTRL_W-1:0];
      end
      // R16: wake on an idle line, or on a character with its top bit set
      if (ctrl_q[CB_RWU] && ((idle_evt_q && !ctrl_q[CB_WAKE_ADDR]) || (rx_done_q
          && ctrl_q[CB_WAKE_ADDR] && rx_data_q[n_data - 4'h1]))) begin
        ctrl_q[CB_RWU] <= 1'b0;
      end
    end
  end

  // R17: transmit buffer ahead of the shifter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_buf_q <= 9'h000;
      vacant_q <= 1'b1;
    end else begin
      // R9: data write fills the buffer
      if (data_wr) begin
        tx_buf_q <= {w_strb_q[1] ? w_data_q[8] : tx_buf_q[8], w_data_q[7:0]};
        vacant_q <= 1'b0;
      // R12: shifter took the character, buffer is vacant again
      end else if (tx_load) begin
        vacant_q <= 1'b1;
      end
    end
  end

  // R19: receive flags; a hardware set wins over a clear in the same cycle
  assign rx_accept = rx_done_q && (!ctrl_q[CB_RWU] || (ctrl_q[CB_WAKE_ADDR]
                     && rx_data_q[n_data - 4'h1]));
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_buf_q <= 9'h000;
      rx_full_q <= 1'b0;
      idle_q <= 1'b0;
      ovr_q <= 1'b0;
      noise_q <= 1'b0;
      frame_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (data_rd) begin
        rx_full_q <= 1'b0;
      end
      if (wr_go && wr_sel == 3'h6) begin
        idle_q <= idle_q & ~wr_word[SB_IDLE];
        ovr_q <= ovr_q & ~wr_word[SB_OVR];
        noise_q <= noise_q & ~wr_word[SB_NOISE];
        frame_q <= frame_q & ~wr_word[SB_FRAME];
        par_q <= par_q & ~wr_word[SB_PAR];
      end
      if (idle_evt_q && !ctrl_q[CB_RWU]) begin
        idle_q <= 1'b1;
      end
      // Overrun keeps the older character
      if (rx_accept && rx_full_q && !data_rd) begin
        ovr_q <= 1'b1;
      end else if (rx_accept) begin
        rx_buf_q <= rx_data_q;
        rx_full_q <= 1'b1;
        // Only a real set may override a clear in the same cycle
        if (rx_nf_q) begin
          noise_q <= 1'b1;
        end
        if (rx_fe_q) begin
          frame_q <= 1'b1;
        end
        if (rx_pe_q) begin
          par_q <= 1'b1;
        end
      end
    end
  end

  // R1: modulo divider runs from clk_i; R2: 13-bit modulus
  // R20: stop mode freezes the divider and both shifters
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baud_cnt_q <= 13'h0000;
      tick_q <= 1'b0;
    end else if (stop_i || div_q == 13'h0000) begin
      tick_q <= 1'b0;
    end else if (baud_cnt_q >= div_q - 13'h0001) begin
      baud_cnt_q <= 13'h0000;
      tick_q <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q + 13'h0001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_state_q <= TX_IDLE;
      tx_sr_q <= SR_IDLE;
      tx_cnt_q <= 4'h0;
      tx_ph_q <= 4'h0;
      tx_on_prev_q <= 1'b0;
      pre_pend_q <= 1'b0;
    end else if (!stop_i) begin
      tx_on_prev_q <= tx_on;
      // R7: queue one idle frame when enabled
      if (tx_on && !tx_on_prev_q) begin
        pre_pend_q <= 1'b1;
      end else if (!tx_on) begin
        pre_pend_q <= 1'b0;
      end else if (tx_free && pre_pend_q) begin
        pre_pend_q <= 1'b0;
      end
      case (tx_state_q)
        TX_IDLE: begin
          tx_ph_q <= 4'h0;
          if (tx_free && pre_pend_q) begin
            tx_state_q <= TX_PRE;
            tx_sr_q <= SR_IDLE;
            tx_cnt_q <= frame_len;
          // R15: break of 13 low bit times
          end else if (tx_free && ctrl_q[CB_BRK]) begin
            tx_state_q <= TX_BRK;
            tx_sr_q <= SR_BREAK;
            tx_cnt_q <= BREAK_LEN;
          // R11: frame built; R14: parity; R22: bit order
          end else if (tx_load) begin
            tx_state_q <= TX_DATA;
            tx_sr_q <= build_frame(tx_buf_q, nine, ctrl_q[CB_PAR_EN], ctrl_q[CB_PAR_ODD]);
            tx_cnt_q <= frame_len;
          end
        end
        TX_PRE, TX_DATA, TX_BRK: begin
          if (tick_q) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == PH_LAST) begin
              tx_sr_q <= {1'b1, tx_sr_q[12:1]};
              tx_cnt_q <= tx_cnt_q - 4'h1;
            end
          end
          if (tx_done) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // R5: idle high; R6: inversion applied at the pin; R21: NRZ drive
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txd_q <= 1'b1;
      txd_oe_q <= 1'b0;
    end else begin
      txd_q <= tx_line ^ ctrl_q[CB_INV];
      txd_oe_q <= tx_on;
    end
  end

  // Receiver runs independently of the transmitter, giving full duplex
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_busy_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_ph_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_samp_q <= 3'h7;
      rx_sr_q <= 9'h000;
      rx_noise_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_fe_q <= 1'b0;
      rx_pe_q <= 1'b0;
      rx_nf_q <= 1'b0;
      rx_data_q <= 9'h000;
    end else if (!stop_i) begin
      rx_prev_q <= rx_line;
      rx_done_q <= 1'b0;
      if (!rx_on) begin
        rx_busy_q <= 1'b0;
      // R3: realign on each falling edge
      end else if (rx_fall) begin
        rx_ph_q <= 4'h0;
        if (!rx_busy_q) begin
          rx_busy_q <= 1'b1;
          rx_idx_q <= 4'h0;
          rx_noise_q <= 1'b0;
        end
      end else if (tick_q && rx_busy_q) begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_ph_q >= PH_S0 && rx_ph_q < PH_S2) begin
          rx_samp_q <= {rx_samp_q[1:0], rx_line};
        end
        if (rx_ph_q == PH_S2) begin
          rx_idx_q <= rx_idx_q + 4'h1;
          rx_noise_q <= rx_noise_q | ~((rx_samp_q[1] == rx_samp_q[0])
                        && (rx_samp_q[0] == rx_line));
          if (rx_idx_q == 4'h0 && rx_bit) begin
            rx_busy_q <= 1'b0;
          end else if (rx_idx_q != 4'h0 && rx_idx_q <= n_data) begin
            rx_sr_q <= {rx_bit, rx_sr_q[8:1]};
          end else if (rx_idx_q > n_data) begin
            // R13: align to 8 or 9 bits; R14: parity check
            rx_busy_q <= 1'b0;
            rx_done_q <= 1'b1;
            rx_data_q <= nine ? rx_sr_q : {1'b0, rx_sr_q[8:1]};
            rx_fe_q <= !rx_bit;
            rx_nf_q <= rx_noise_q | ~((rx_samp_q[1] == rx_samp_q[0])
                       && (rx_samp_q[0] == rx_line));
            rx_pe_q <= ctrl_q[CB_PAR_EN] && ((nine ? ^rx_sr_q : ^rx_sr_q[8:1])
                       != ctrl_q[CB_PAR_ODD]);
          end
        end
      end
    end
  end

  // R19: idle after a full frame of high line following a character
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt_q <= 8'h00;
      idle_arm_q <= 1'b0;
      idle_evt_q <= 1'b0;
    end else if (!stop_i) begin
      idle_evt_q <= 1'b0;
      if (rx_done_q) begin
        idle_arm_q <= 1'b1;
        idle_cnt_q <= 8'h00;
      end else if (rx_busy_q || !rx_line) begin
        idle_cnt_q <= 8'h00;
      end else if (tick_q && idle_arm_q) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
        if (idle_cnt_q == {frame_len, 4'h0} - 8'h01) begin
          idle_evt_q <= 1'b1;
          idle_arm_q <= 1'b0;
        end
      end
    end
  end

  assign txd_o = txd_q;
  assign txd_oe_o = txd_oe_q;
  assign awready_o = aw_rdy_q;
  assign wready_o = w_rdy_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign arready_o = ar_rdy_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o = rdata_q;
  assign rresp_o = rresp_q;

  sequence s_tx_enable;
    tx_on && !tx_on_prev_q && !stop_i;
  endsequence
  sequence s_pre_sent;
    tx_free && pre_pend_q ##1 (tx_state_q == TX_PRE && tx_sr_q == SR_IDLE);
  endsequence

  property p_idle_level;
    @(posedge clk_i) disable iff (!arst_n_i)
      (tx_state_q == TX_IDLE && !ctrl_q[CB_INV]) |=> txd_o;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle line not high"); // R5
  property p_invert;
    @(posedge clk_i) disable iff (!arst_n_i)
      (tx_state_q == TX_IDLE && ctrl_q[CB_INV]) |=> !txd_o;
  endproperty
  a_invert: assert property (p_invert) else $error("inverted idle not low"); // R6
  property p_preamble;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_tx_enable |=> pre_pend_q;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble not queued"); // R7
  property p_pre_load;
    @(posedge clk_i) disable iff (!arst_n_i)
      (tx_free && pre_pend_q) |-> s_pre_sent;
  endproperty
  a_pre_load: assert property (p_pre_load) else $error("preamble not idle frame"); // R7
  property p_data_wr;
    @(posedge clk_i) disable iff (!arst_n_i)
      data_wr |=> (!vacant_q && tx_buf_q[7:0] == $past(w_data_q[7:0]));
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write lost"); // R9
  property p_load_len;
    @(posedge clk_i) disable iff (!arst_n_i)
      (tx_load && !data_wr) |=> (vacant_q && tx_state_q == TX_DATA
      && tx_cnt_q == (nine ? FRAME9 : FRAME8) && tx_sr_q[0] == 1'b0);
  endproperty
  a_load_len: assert property (p_load_len) else $error("bad frame load"); // R12
  property p_break;
    @(posedge clk_i) disable iff (!arst_n_i)
      (tx_free && !pre_pend_q && ctrl_q[CB_BRK]) |=> (tx_cnt_q == BREAK_LEN
      && tx_sr_q == SR_BREAK);
  endproperty
  a_break: assert property (p_break) else $error("break length wrong"); // R15
  property p_realign;
    @(posedge clk_i) disable iff (!arst_n_i)
      (rx_fall && rx_on) |=> (rx_ph_q == 4'h0 && rx_busy_q);
  endproperty
  a_realign: assert property (p_realign) else $error("no realign on edge"); // R3
  property p_stop;
    @(posedge clk_i) disable iff (!arst_n_i)
      stop_i |=> ($stable(tx_cnt_q) && $stable(rx_ph_q) && !tick_q);
  endproperty
  a_stop: assert property (p_stop) else $error("activity in stop mode"); // R20
  property p_overrun;
    @(posedge clk_i) disable iff (!arst_n_i)
      (rx_accept && rx_full_q && !data_rd) |=> (ovr_q && $stable(rx_buf_q));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R19
endmodule
`default_nettype wire

// >>> bench/remote_serial_model.sv
// Remote serial transceiver running at the same baud rate as the block
`timescale 1ns/1ns
`default_nettype none
module remote_serial_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic send_i,
  input wire logic [7:0] send_data_i,
  output logic line_o,
  output logic [7:0] rx_data_o,
  output int rx_count_o
);
  logic [7:0] sh;
  initial begin
    line_o = 1'b1;
    rx_data_o = 8'h00;
    rx_count_o = 0;
  end
  always begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      sh[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    rx_data_o = sh;
    rx_count_o++;
  end
  always @(posedge send_i) begin
    for (int i = 0; i < 10; i++) begin
      line_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : send_data_i[i-1];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  end
endmodule
`default_nettype wire

// >>> bench/async_serial_transmitter_tb.sv
// Self-checking bench for the serial transmitter block
`timescale 1ns/1ns
`default_nettype none
module async_serial_transmitter_tb;
  import uart_pkg::*;
  localparam int DIV = 2;
  typedef struct {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rdata;
  } row_t;
  row_t rows [3] = '{'{OFF_BAUD, 32'hFFFFFFFF, RESP_OKAY, 32'h00001FFF},
    '{8'h10, 32'h00001234, RESP_SLVERR, 32'h00000000},
    '{OFF_BAUD, 32'(DIV), RESP_OKAY, 32'(DIV)}};
  logic clk_i, arst_n_i, stop_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, send;
  logic [7:0] awaddr_i, araddr_i, send_d;
  logic [31:0] wdata_i, d;
  logic [3:0] wstrb_i;
  logic [1:0] r;
  wire logic txd_o, txd_oe_o, awready_o, wready_o, bvalid_o, arready_o, rvalid_o, rxd;
  wire logic [1:0] bresp_o, rresp_o;
  wire logic [31:0] rdata_o;
  wire logic [7:0] rx_data;
  int rx_count, checks, miscompares, cyc;
  time t0;
  // Released pin idles high
  wire logic pin = txd_oe_o ? txd_o : 1'b1;
  uart_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .stop_i(stop_i), .rxd_i(rxd),
    .txd_i(pin), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i));
  remote_serial_model #(.BIT_CLKS(DIV * 16)) far_end (.clk_i(clk_i), .line_i(pin),
    .send_i(send), .send_data_i(send_d), .line_o(rxd), .rx_data_o(rx_data),
    .rx_count_o(rx_count));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // Ready signals stay high, so a response is taken where it is first seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready_o === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w_ok && wready_o === 1'b1) begin
        w_ok = 1'b1;
        wvalid_i <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid_o !== 1'b1);
    resp = bresp_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    do @(posedge clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge clk_i); while (rvalid_o !== 1'b1);
    v = rdata_o;
    resp = rresp_o;
  endtask
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (10000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
  initial begin
    {arst_n_i, stop_i, awvalid_i, wvalid_i, arvalid_i, send} = '0;
    {bready_i, rready_i} = 2'b11;
    {awaddr_i, araddr_i, send_d, wdata_i} = '0;
    wstrb_i = 4'hF;
    do_reset();
    foreach (rows[k]) begin
      wr(rows[k].addr, rows[k].wdata, r);
      chk("bresp", 32'(rows[k].resp), 32'(r));
      rd(rows[k].addr, d, r);
      chk("rresp", 32'(rows[k].resp), 32'(r));
      chk("rdata", rows[k].rdata, d);
    end
    $display("register rows done");
    do_reset();
    chk("idle line", 32'h1, 32'(txd_o));
    chk("pin enable", 32'h0, 32'(txd_oe_o));
    rd(OFF_BAUD, d, r);
    chk("baud reset", 32'(DIV_RST), d);
    rd(OFF_STAT, d, r);
    chk("vacant reset", 32'h1, 32'(d[SB_VACANT]));
    wr(OFF_BAUD, 32'(DIV), r);
    wr(OFF_CTRL, 32'h1, r);
    t0 = $time;
    wr(OFF_DATA, 32'hA5, r);
    rd(OFF_STAT, d, r);
    chk("vacant after write", 32'h0, 32'(d[SB_VACANT]));
    chk("pin enable on", 32'h1, 32'(txd_oe_o));
    while (txd_o !== 1'b0) @(posedge clk_i);
    cyc = int'(($time - t0) / 8);
    chk("preamble", 32'h1, 32'(cyc >= 160 * DIV && cyc < 168 * DIV));
    do rd(OFF_STAT, d, r); while (d[SB_VACANT] !== 1'b1);
    wr(OFF_DATA, 32'h3C, r);
    wait (rx_count == 1);
    chk("frame one", 32'hA5, 32'(rx_data));
    wait (rx_count == 2);
    chk("frame two", 32'h3C, 32'(rx_data));
    $display("transmit done");
    wr(OFF_CTRL, 32'h3, r);
    send_d <= 8'h96;
    send <= 1'b1;
    repeat (12 * 16 * DIV) @(posedge clk_i);
    send <= 1'b0;
    rd(OFF_STAT, d, r);
    chk("rx full", 32'h1, 32'(d[SB_RXFULL]));
    chk("tx complete", 32'h1, 32'(d[SB_TC]));
    rd(OFF_DATA, d, r);
    chk("rx data", 32'h96, {24'h0, d[7:0]});
    // Loop mode, nine bits, even parity in bit 8
    wr(OFF_CTRL, 32'h8F, r);
    wr(OFF_DATA, 32'h5B, r);
    do rd(OFF_STAT, d, r); while (d[SB_RXFULL] !== 1'b1);
    chk("parity flag", 32'h0, 32'(d[SB_PAR]));
    rd(OFF_DATA, d, r);
    chk("loop nine parity", 32'h15B, d);
    wr(OFF_CTRL, 32'h21, r);
    repeat (2) @(posedge clk_i);
    chk("inverted idle", 32'h0, 32'(txd_o));
    $display("receive and invert done");
    stop_i <= 1'b1;
    wr(OFF_DATA, 32'h0F, r);
    repeat (64) @(posedge clk_i);
    rd(OFF_STAT, d, r);
    chk("stop freeze", 32'h0, 32'(d[SB_VACANT]));
    stop_i <= 1'b0;
    do rd(OFF_STAT, d, r); while (d[SB_TC] !== 1'b1);
    wr(OFF_CTRL, 32'h41, r);
    repeat (3 * 16 * DIV) @(posedge clk_i);
    chk("break low", 32'h0, 32'(txd_o));
    $display("stop and break done");
    final_report();
  end
endmodule
`default_nettype wire
